// file: rtl/mem_map_pkg.sv
// constants and types shared by the memory map decode block
package mem_map_pkg;
  // program flash sizes and upper limits
  typedef enum logic [1:0] {flash_8k, flash_4k, flash_2k} flash_variant_t;
  localparam logic [15:0] flash_top_8k     = 16'h1DFF;
  localparam logic [15:0] flash_top_4k     = 16'h0FFF;
  localparam logic [15:0] flash_top_2k     = 16'h07FF;
  localparam logic [15:0] flash_base       = 16'h0000;
  // special function register addresses
  localparam logic [7:0]  stack_top_pointer_addr     = 8'h81;
  localparam logic [7:0]  program_store_control_addr = 8'h8F;
  localparam logic [7:0]  processor_status_word_addr = 8'hD0;
  localparam logic [7:0]  stack_top_pointer_reset    = 8'h07;
  localparam logic [7:0]  program_store_control_reset = 8'h00;
  localparam logic [7:0]  processor_status_word_reset = 8'h00;
  // field positions
  localparam int          store_write_enable_bit = 0;
  localparam int          bank_select_low_bit    = 3;
  localparam int          bank_select_high_bit   = 4;
  // data memory layout
  localparam logic [7:0]  sfr_space_base   = 8'h80;
  localparam logic [7:0]  bit_area_base    = 8'h20;
  localparam logic [2:0]  sfr_bit_low_nib  = 3'h0;
  localparam int          ram_depth        = 256;
  // operand kinds the core can present
  typedef enum logic [1:0] {acc_direct, acc_indirect, acc_bit} access_mode_t;
endpackage

// file: rtl/data_ram.sv
// 256 byte internal data memory with one synchronous port
`timescale 1ns/1ps
module data_ram
  import mem_map_pkg::*;
(
  input  wire logic       core_clk, // system clock
  input  wire logic       we,       // write strobe
  input  wire logic [7:0] addr,     // byte address
  input  wire logic [7:0] wdata,    // write data
  output logic      [7:0] rdata     // registered read data
);
  logic [7:0] mem [ram_depth];

  // read-first; the core sees old data on a same-address write
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// file: rtl/sfr_core_regs.sv
// the three special function registers owned by the memory map block
`timescale 1ns/1ps
module sfr_core_regs
  import mem_map_pkg::*;
(
  input  wire logic       core_clk,   // system clock
  input  wire logic       srst,       // synchronous reset, active high
  input  wire logic       wr_en,      // byte or bit write to a register
  input  wire logic [7:0] wr_addr,    // register address
  input  wire logic [7:0] wr_data,    // merged write byte
  input  wire logic       sp_push,    // stack pointer increment
  input  wire logic       sp_pop,     // stack pointer decrement
  output logic      [7:0] sp_q,       // stack top pointer
  output logic      [7:0] program_store_control_q,    // program store control
  output logic      [7:0] psw_q       // processor status word
);
  logic [7:0] sp_d;

  // a direct write beats a stack move in the same cycle
  assign sp_d = (wr_en && wr_addr == stack_top_pointer_addr) ? wr_data :
                sp_push ? 8'(sp_q + 8'h01) :
                sp_pop  ? 8'(sp_q - 8'h01) : sp_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_q    <= stack_top_pointer_reset;
      program_store_control_q <= program_store_control_reset;
      psw_q   <= processor_status_word_reset;
    end else begin
      sp_q <= sp_d;
      if (wr_en && wr_addr == program_store_control_addr) begin
        program_store_control_q <= wr_data;
      end
      if (wr_en && wr_addr == processor_status_word_addr) begin
        psw_q <= wr_data;
      end
    end
  end
endmodule

// file: rtl/data_memory_map_decode.sv
// memory space decode: program flash limits, internal ram, sfr routing
`timescale 1ns/1ps
module data_memory_map_decode
  import mem_map_pkg::*;
#(
  parameter flash_variant_t variant = flash_8k // fitted flash size
) (
  input  wire logic              core_clk,      // system clock
  input  wire logic              srst,          // synchronous reset, active high
  // data access from the core
  input  wire logic              acc_req,       // one-cycle access request
  input  wire access_mode_t      acc_mode,      // direct, indirect or bit operand
  input  wire logic              acc_wr,        // write when high
  input  wire logic [7:0]        acc_addr,      // direct address or bit address
  input  wire logic              acc_use_r1,    // indirect pointer is register one
  input  wire logic [7:0]        acc_wdata,     // byte data or bit in bit 0
  output logic      [7:0]        acc_rdata,     // read data, bit in bit 0
  output logic                   acc_valid,     // read data valid pulse
  output logic                   acc_error,     // bit access to byte-only sfr
  // stack operations
  input  wire logic              push_req,      // push acc_wdata
  input  wire logic              pop_req,       // pop into acc_rdata
  // external sfr space
  output logic                   sfr_rd,        // read strobe for outside sfrs
  output logic                   sfr_wr,        // write strobe for outside sfrs
  output logic      [7:0]        sfr_addr,      // outside sfr address
  output logic      [7:0]        sfr_wdata,     // outside sfr write byte
  input  wire logic [7:0]        sfr_rdata,     // outside sfr read byte
  // program memory
  input  wire logic              movx_wr,       // external-data write instruction
  input  wire logic [15:0]       prog_addr,     // program address
  output logic                   flash_wr,      // flash write strobe
  output logic                   xram_wr,       // normal external data write
  output logic                   prog_reserved, // address outside fitted flash
  output logic      [7:0]        stack_ptr,     // stack top pointer value
  output logic      [1:0]        active_bank    // selected working bank
);
  logic [7:0] sp_q, program_store_control_q, psw_q;
  logic [7:0] ram_rdata;
  logic       pend_q, pend_bit_q, pend_sfr_q, pend_own_q;
  logic [2:0] pend_pos_q;
  logic [7:0] pend_addr_q;
  logic [7:0] own_rdata;
  logic [15:0] flash_top;

  // flash upper limit by fitted size
  function automatic logic [15:0] top_of(input flash_variant_t v);
    case (v)
      flash_8k: top_of = flash_top_8k;
      flash_4k: top_of = flash_top_4k;
      flash_2k: top_of = flash_top_2k;
      default:  top_of = flash_top_2k;
    endcase
  endfunction

  // sfr registers handled inside this block
  function automatic logic is_own(input logic [7:0] a);
    is_own = (a == stack_top_pointer_addr) || (a == program_store_control_addr) ||
             (a == processor_status_word_addr);
  endfunction

  // program space decode
  assign flash_top     = top_of(variant);
  assign prog_reserved = (prog_addr > flash_top);
  assign flash_wr      = movx_wr && program_store_control_q[store_write_enable_bit];
  assign xram_wr       = movx_wr && !program_store_control_q[store_write_enable_bit];

  // working bank and indirect pointer location
  logic [1:0] bank;
  logic [7:0] ptr_loc;
  assign bank        = {psw_q[bank_select_high_bit], psw_q[bank_select_low_bit]};
  assign active_bank = bank;
  assign ptr_loc     = {3'h0, bank, 2'h0, acc_use_r1};
  assign stack_ptr   = sp_q;

  // bit address decode; top half names bits in bit-addressable sfrs
  logic       bit_is_sfr;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  assign bit_is_sfr = acc_addr[7];
  assign bit_pos    = acc_addr[2:0];
  assign bit_byte   = bit_is_sfr ? {acc_addr[7:3], sfr_bit_low_nib}
                                 : 8'(bit_area_base + {4'h0, acc_addr[6:3]});

  // indirect accesses take two steps: fetch the pointer, then the byte
  typedef enum logic [1:0] {st_idle, st_ptr, st_use} ind_state_t;
  ind_state_t st_q, st_d;
  logic       ind_wr_q;
  logic [7:0] ind_wdata_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      st_idle: if (acc_req && acc_mode == acc_indirect) st_d = st_ptr;
      st_ptr:  st_d = st_use;
      st_use:  st_d = st_idle;
      default: st_d = st_idle;
    endcase
  end

  // routing of the current cycle's access
  logic       is_bit, is_dir, is_ind;
  logic       to_sfr, bit_ok;
  logic [7:0] tgt;
  assign is_bit = acc_req && st_q == st_idle && acc_mode == acc_bit;
  assign is_dir = acc_req && st_q == st_idle && acc_mode == acc_direct;
  assign is_ind = (st_q == st_use);
  // bit access never reaches byte-only sfrs; reserved holes pass outside undefined
  assign bit_ok = 1'b1; // every bit address maps to a bit-capable byte
  assign tgt    = is_bit ? bit_byte : acc_addr;
  assign to_sfr = (is_dir && acc_addr >= sfr_space_base) ||
                  (is_bit && bit_is_sfr);

  // ram port: stack, pointer fetch, indirect use, direct low half
  logic       ram_we;
  logic [7:0] ram_addr, ram_wdata;
  logic [7:0] merged;
  logic       stack_rd;
  assign stack_rd = pop_req && !acc_req && st_q == st_idle;
  assign ram_addr = (st_q == st_ptr) ? ptr_loc :
                    is_ind ? ram_rdata : // pointer byte read one step before
                    (push_req && st_q == st_idle) ? 8'(sp_q + 8'h01) :
                    stack_rd ? sp_q : tgt;
  assign ram_we   = (is_ind && ind_wr_q) ||
                    (push_req && !acc_req && st_q == st_idle) ||
                    (is_dir && acc_wr && !to_sfr);
  assign ram_wdata = is_ind ? ind_wdata_q : acc_wdata;

  // bit writes to own registers are read-modify-write on the owning byte
  function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] p,
                                         input logic v);
    logic [7:0] r;
    r = b;
    r[p] = v;
    set_bit = r;
  endfunction
  // live value of the addressed own register, so a bit write keeps the other bits
  logic [7:0] own_now;
  logic [7:0] own_wr_data;
  assign own_now     = (tgt == stack_top_pointer_addr)     ? sp_q :
                       (tgt == program_store_control_addr) ? program_store_control_q : psw_q;
  assign merged      = set_bit(own_now, bit_pos, acc_wdata[0]);
  assign own_wr_data = is_bit ? merged : acc_wdata;

  // outside sfr strobes; bit writes here pass the bit in bit 0 with address
  assign sfr_rd    = to_sfr && !is_own(tgt) && !acc_wr;
  assign sfr_wr    = to_sfr && !is_own(tgt) && acc_wr;
  assign sfr_addr  = tgt;
  assign sfr_wdata = acc_wdata;

  // own register writes: direct byte writes and bit writes to the status word
  logic own_wr;
  assign own_wr = (is_dir || is_bit) && acc_wr && to_sfr && is_own(tgt);

  sfr_core_regs u_regs (
    .core_clk (core_clk),
    .srst     (srst),
    .wr_en    (own_wr),
    .wr_addr  (tgt),
    .wr_data  (own_wr_data),
    .sp_push  (push_req && !acc_req && st_q == st_idle),
    .sp_pop   (stack_rd),
    .sp_q     (sp_q),
    .program_store_control_q  (program_store_control_q),
    .psw_q    (psw_q)
  );

  data_ram u_ram (
    .core_clk (core_clk),
    .we       (ram_we),
    .addr     (ram_addr),
    .wdata    (ram_wdata),
    .rdata    (ram_rdata)
  );

  // own register read mux
  always_comb begin
    case (pend_addr_q)
      stack_top_pointer_addr:     own_rdata = sp_q;
      program_store_control_addr: own_rdata = program_store_control_q;
      processor_status_word_addr: own_rdata = psw_q;
      default:                    own_rdata = 8'h00;
    endcase
  end

  // read return path; data lands two cycles after a direct, bit or pop request, four after an indirect one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q        <= st_idle;
      ind_wr_q    <= 1'b0;
      ind_wdata_q <= 8'h00;
      pend_q      <= 1'b0;
      pend_bit_q  <= 1'b0;
      pend_sfr_q  <= 1'b0;
      pend_own_q  <= 1'b0;
      pend_pos_q  <= 3'h0;
      pend_addr_q <= 8'h00;
      acc_rdata   <= 8'h00;
      acc_valid   <= 1'b0;
      acc_error   <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == st_idle && acc_req && acc_mode == acc_indirect) begin
        ind_wr_q    <= acc_wr;
        ind_wdata_q <= acc_wdata;
      end
      // a stale write flag must not swallow a pop answer
      pend_q      <= (is_dir || is_bit || (is_ind && !ind_wr_q) || stack_rd) &&
                     !(acc_req && acc_wr && !is_ind);
      pend_bit_q  <= is_bit;
      pend_sfr_q  <= to_sfr;
      pend_own_q  <= to_sfr && is_own(tgt);
      pend_pos_q  <= bit_pos;
      pend_addr_q <= tgt;
      acc_error   <= is_bit && !bit_ok;
      acc_valid   <= pend_q;
      if (pend_q) begin
        logic [7:0] raw;
        raw = pend_own_q ? own_rdata : pend_sfr_q ? sfr_rdata : ram_rdata;
        acc_rdata <= pend_bit_q ? {7'h00, raw[pend_pos_q]} : raw;
      end
    end
  end

  // bit writes to ram bytes are left to a read-modify-write by the core
endmodule

// file: dv/mem_map_asserts.sv
// port level assertions for the memory map decode block
`timescale 1ns/1ps
module mem_map_asserts
  import mem_map_pkg::*;
#(
  parameter flash_variant_t variant = flash_8k // fitted flash size
) (
  input wire logic         core_clk,      // system clock
  input wire logic         srst,          // synchronous reset
  input wire logic         acc_req,       // access request
  input wire access_mode_t acc_mode,      // operand kind
  input wire logic         acc_wr,        // write access
  input wire logic [7:0]   acc_addr,      // access address
  input wire logic [7:0]   acc_wdata,     // write data
  input wire logic         acc_valid,     // read data valid
  input wire logic         acc_error,     // bit access error
  input wire logic         push_req,      // push pulse
  input wire logic         pop_req,       // pop pulse
  input wire logic         sfr_rd,        // outside sfr read
  input wire logic         sfr_wr,        // outside sfr write
  input wire logic [7:0]   sfr_addr,      // outside sfr address
  input wire logic [7:0]   sfr_wdata,     // outside sfr data
  input wire logic         movx_wr,       // external data write
  input wire logic [15:0]  prog_addr,     // program address
  input wire logic         flash_wr,      // flash write strobe
  input wire logic         xram_wr,       // external ram write
  input wire logic         prog_reserved, // reserved flash address
  input wire logic [7:0]   stack_ptr      // stack pointer
);
  localparam logic [15:0] top = (variant == flash_8k) ? flash_top_8k :
                                (variant == flash_4k) ? flash_top_4k : flash_top_2k;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // the three own registers never leave on the outside strobes
  wire logic own_sfr = acc_addr inside {8'h81, 8'h8F, 8'hD0};
  wire logic dir_hi  = acc_req && acc_mode == acc_direct && acc_addr[7] && !own_sfr;
  sequence dir_rd; acc_req && acc_mode != acc_indirect && !acc_wr; endsequence
  sequence ind_rd; acc_req && acc_mode == acc_indirect && !acc_wr; endsequence
  sequence no_sfr4; (!sfr_rd && !sfr_wr)[*4]; endsequence
  a_reset_sp_val: assert property ($fell(srst) |-> stack_ptr == 8'h07)
    else $error("stack pointer not 07 after reset");
  a_dir_sfr_rd: assert property (dir_hi && !acc_wr |-> sfr_rd && sfr_addr == acc_addr)
    else $error("direct upper read not sent to sfr space");
  a_dir_sfr_wr: assert property (dir_hi && acc_wr |-> sfr_wr && sfr_wdata == acc_wdata)
    else $error("direct upper write not sent to sfr space");
  a_low_ram_local: assert property (acc_req && !acc_addr[7] && acc_mode == acc_direct
    |-> !sfr_rd && !sfr_wr)
    else $error("low ram access leaked to sfr space");
  a_ind_upper_ram: assert property (ind_rd |-> no_sfr4 ##1 acc_valid)
    else $error("indirect read touched sfr or missed latency");
  a_dir_read_lat: assert property (dir_rd |-> ##2 acc_valid)
    else $error("direct or bit read latency wrong");
  a_push_step: assert property (push_req && !acc_req |=> stack_ptr == $past(stack_ptr) + 8'h01)
    else $error("push did not advance pointer");
  a_pop_step: assert property (pop_req && !acc_req |=> stack_ptr == $past(stack_ptr) - 8'h01
    ##1 acc_valid)
    else $error("pop did not retreat pointer or answer");
  a_flash_gate: assert property (flash_wr |-> movx_wr && !xram_wr)
    else $error("flash write without write instruction");
  a_flash_limit: assert property (prog_reserved == (prog_addr > top))
    else $error("reserved flash decode wrong");
  a_no_bit_error: assert property (!acc_error)
    else $error("unexpected access error");
endmodule
bind data_memory_map_decode mem_map_asserts #(.variant(variant)) u_chk (.core_clk(core_clk),
  .srst(srst), .acc_req(acc_req), .acc_mode(acc_mode), .acc_wr(acc_wr), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_valid(acc_valid), .acc_error(acc_error), .push_req(push_req),
  .pop_req(pop_req), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .movx_wr(movx_wr), .prog_addr(prog_addr), .flash_wr(flash_wr),
  .xram_wr(xram_wr), .prog_reserved(prog_reserved), .stack_ptr(stack_ptr));

// file: dv/sfr_model.sv
// outside special function registers answering the decode block
`timescale 1ns/1ps
module sfr_model (
  input  wire logic       core_clk,  // system clock
  input  wire logic       sfr_rd,    // read strobe
  input  wire logic       sfr_wr,    // write strobe
  input  wire logic [7:0] sfr_addr,  // register address
  input  wire logic [7:0] sfr_wdata, // write byte
  output logic      [7:0] sfr_rdata  // read byte
);
  logic [7:0] regs_q [0:127];
  logic [7:0] hold_q;
  initial begin
    hold_q = 8'h00;
    for (int i = 0; i < 128; i++) regs_q[i] = 8'h00;
  end
  // data shows during the strobe and one cycle after, then toggles so stale reads show
  assign sfr_rdata = sfr_rd ? regs_q[sfr_addr[6:0]] : hold_q;
  always @(posedge core_clk) begin
    if (sfr_wr) regs_q[sfr_addr[6:0]] <= sfr_wdata;
    hold_q <= sfr_rd ? regs_q[sfr_addr[6:0]] : ~hold_q;
  end
endmodule

// file: dv/data_memory_map_decode_test.sv
// self-checking bench for the memory map decode block
`timescale 1ns/1ps
module data_memory_map_decode_test;
  import mem_map_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, acc_req = 1'b0, acc_wr = 1'b0, acc_use_r1 = 1'b0;
  logic push_req = 1'b0, pop_req = 1'b0, movx_wr = 1'b0;
  access_mode_t acc_mode = acc_direct;
  logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00;
  logic [15:0] prog_addr = 16'h0000;
  logic [7:0] acc_rdata, sfr_addr, sfr_wdata, sfr_rdata, stack_ptr;
  logic acc_valid, acc_error, sfr_rd, sfr_wr, flash_wr, xram_wr, prog_reserved;
  logic [1:0] active_bank;
  int bad_count = 0, num_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  data_memory_map_decode i_dut (.core_clk(core_clk), .srst(srst), .acc_req(acc_req),
    .acc_mode(acc_mode), .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_use_r1(acc_use_r1),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_valid(acc_valid), .acc_error(acc_error),
    .push_req(push_req), .pop_req(pop_req), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .movx_wr(movx_wr),
    .prog_addr(prog_addr), .flash_wr(flash_wr), .xram_wr(xram_wr),
    .prog_reserved(prog_reserved), .stack_ptr(stack_ptr), .active_bank(active_bank));
  sfr_model u_sfr (.core_clk(core_clk), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for the read answer under a bound, a hung answer counts as a mismatch
  task automatic get(input logic bit_op, input logic [7:0] exp);
    int n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (acc_valid !== 1'b1 && n < 8);
    chk({7'h00, acc_valid}, 8'h01);
    chk(bit_op ? {7'h00, acc_rdata[0]} : acc_rdata, exp);
  endtask
  // one access, then idle long enough to respect indirect spacing
  task automatic acc(input access_mode_t m, input logic w, input logic [7:0] a,
                     input logic r1, input logic [7:0] d, input logic [7:0] exp);
    @(posedge core_clk);
    acc_req <= 1'b1; acc_mode <= m; acc_wr <= w; acc_addr <= a; acc_use_r1 <= r1;
    acc_wdata <= d;
    @(posedge core_clk);
    acc_req <= 1'b0;
    if (!w) get(m == acc_bit, exp);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic stk(input logic psh, input logic [7:0] d, input logic [7:0] exp);
    @(posedge core_clk);
    push_req <= psh; pop_req <= !psh; acc_wdata <= d;
    @(posedge core_clk);
    push_req <= 1'b0; pop_req <= 1'b0;
    if (!psh) get(1'b0, exp);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_ram_modes();
    acc(acc_direct, 1, 8'h30, 0, 8'hA5, 0);
    acc(acc_direct, 0, 8'h30, 0, 0, 8'hA5);
    acc(acc_direct, 1, 8'h00, 0, 8'h30, 0);
    acc(acc_indirect, 0, 8'h00, 0, 0, 8'hA5);
  endtask
  task automatic t_upper_split();
    acc(acc_direct, 1, 8'h01, 0, 8'h90, 0);
    acc(acc_indirect, 1, 8'h00, 1, 8'h3C, 0);
    acc(acc_direct, 1, 8'h90, 0, 8'hC3, 0);
    acc(acc_direct, 0, 8'h90, 0, 0, 8'hC3);
    acc(acc_indirect, 0, 8'h00, 1, 0, 8'h3C);
  endtask
  task automatic t_banks();
    acc(acc_direct, 1, 8'hD0, 0, 8'h18, 0);
    #1 chk({6'h00, active_bank}, 8'h03);
    acc(acc_direct, 1, 8'h18, 0, 8'h40, 0);
    acc(acc_direct, 1, 8'h40, 0, 8'h5A, 0);
    acc(acc_indirect, 0, 8'h00, 0, 0, 8'h5A);
    acc(acc_bit, 0, 8'hD3, 0, 0, 8'h01);
    acc(acc_bit, 1, 8'hD3, 0, 8'h00, 0);
    #1 chk({6'h00, active_bank}, 8'h02);
    acc(acc_direct, 1, 8'hD0, 0, 8'h00, 0);
  endtask
  task automatic t_bits();
    acc(acc_direct, 1, 8'h22, 0, 8'h08, 0);
    acc(acc_direct, 1, 8'h2F, 0, 8'h80, 0);
    acc(acc_bit, 0, 8'h13, 0, 0, 8'h01);
    acc(acc_bit, 0, 8'h12, 0, 0, 8'h00);
    acc(acc_bit, 0, 8'h7F, 0, 0, 8'h01);
  endtask
  task automatic t_stack();
    chk(stack_ptr, 8'h07);
    stk(1, 8'h11, 0);
    stk(1, 8'h22, 0);
    chk(stack_ptr, 8'h09);
    acc(acc_direct, 0, 8'h08, 0, 0, 8'h11);
    acc(acc_direct, 0, 8'h81, 0, 0, 8'h09);
    stk(0, 0, 8'h22);
    chk(stack_ptr, 8'h08);
  endtask
  task automatic t_flash();
    logic [15:0] pa [2] = '{16'h1DFF, 16'h1E00};
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      prog_addr <= pa[i];
      #1 chk({7'h00, prog_reserved}, {7'h00, i == 1});
    end
    @(posedge core_clk);
    movx_wr <= 1'b1;
    #1 chk({6'h00, flash_wr, xram_wr}, 8'h01);
    acc(acc_direct, 1, 8'h8F, 0, 8'h01, 0);
    #1 chk({6'h00, flash_wr, xram_wr}, 8'h02);
  endtask
  // cuts a hang short after far more cycles than the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_stack();
    t_ram_modes();
    t_upper_split();
    t_banks();
    t_bits();
    t_flash();
    print_verdict();
  end
endmodule
